// >>> src/twp_pkg.sv
//==========================================================
//==========================================================
package twp_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam logic [7:0] ADDR_TIMER = 8'h05;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_WDOG = 8'h11;
  localparam logic [7:0] ADDR_STAT = 8'h12;
  localparam int unsigned CTRL_SRC_BIT = 5;
  localparam int unsigned CTRL_EDGE_BIT = 4;
  localparam int unsigned CTRL_PRE_EN_BIT = 3;
  localparam int unsigned WD_EN_BIT = 7;
  localparam int unsigned WD_PRE_EN_BIT = 5;
  localparam int unsigned WD_RATE_LSB = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] WDOG_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h3F;
  localparam logic [7:0] WDOG_MASK = 8'hBC;
  localparam int unsigned WD_TIMEOUT_US = 18000;
  localparam int unsigned WD_RC_HZ = 1000000;
  localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_US * (WD_RC_HZ / 1000000);
  localparam int unsigned INSTR_DIV = 2;
endpackage

// >>> src/twp_pre_if.sv
`timescale 1ns/10ps
`default_nettype none
//==========================================================
// prescaler tap port
interface twp_pre_if;
  logic tick;
  logic clear;
  logic bypass;
  logic [2:0] rate;
  logic out;
  modport owner (output tick, output clear, output bypass, output rate, input out);
  modport pre (input tick, input clear, input bypass, input rate, output out);
endinterface
`default_nettype wire

// >>> src/twp_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
//==========================================================
// eight-bit prescaler, tap 000 = /2 .. 111 = /256
module twp_prescaler #(
  parameter int unsigned W = 8
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  twp_pre_if.pre p
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_inc;
  assign cnt_inc = cnt_q + {{(W-1){1'b0}}, 1'b1};
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || (ce_i && p.clear)) begin
      cnt_q <= '0;
    end else if (ce_i && p.tick) begin
      cnt_q <= cnt_inc;
    end
  end
  // output pulses when the selected bit falls, a full period after clear; in bypass it pulses on every tick not in a clear cycle
  always_comb begin
    if (p.bypass) begin
      p.out = p.tick && !p.clear;
    end else begin
      p.out = p.tick && !p.clear && (cnt_q[p.rate] && !cnt_inc[p.rate]);
    end
  end
endmodule
`default_nettype wire

// >>> src/twp_top.sv
`timescale 1ns/10ps
`default_nettype none
module twp_top #(
  parameter int unsigned WD_TIMEOUT = twp_pkg::WD_TIMEOUT_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wd_rc_tick_i,
  input wire logic timer_pin_i,
  input wire logic sleep_instr_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic sleep_o,
  output logic wd_reset_o
);
  //==========================================================
  // registers
  logic [7:0] timer_q;
  logic [7:0] ctrl_q;
  logic [7:0] wdog_q;
  logic sleep_q;
  logic wd_rst_q;
  logic [7:0] rdata_q;
  logic instr_q;
  logic [2:0] pin_q;
  logic pin_lvl_q;
  logic [31:0] wd_cnt_q;
  logic wr_timer, wr_ctrl, wr_wdog, clr_wd, tmr_src, tmr_edge_ok;
  twp_pre_if tpre();
  twp_pre_if wpre();

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  assign wr_timer = wr_i && hit(addr_i, twp_pkg::ADDR_TIMER);
  assign wr_ctrl = wr_i && hit(addr_i, twp_pkg::ADDR_CTRL);
  assign wr_wdog = wr_i && hit(addr_i, twp_pkg::ADDR_WDOG);
  assign clr_wd = watchdog_clear_instr_i || sleep_instr_i;

  //==========================================================
  // control registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_q <= twp_pkg::CTRL_RESET;
    end else if (ce_i && wr_ctrl) begin
      ctrl_q <= wdata_i & twp_pkg::CTRL_MASK;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wdog_q <= twp_pkg::WDOG_RESET;
    end else if (ce_i && wr_wdog && !sleep_q) begin
      wdog_q <= wdata_i & twp_pkg::WDOG_MASK;
    end
  end

  //==========================================================
  // sleep state, left by reset only
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sleep_q <= 1'b0;
    end else if (ce_i && sleep_instr_i) begin
      sleep_q <= 1'b1;
    end
  end

  //==========================================================
  // pin sync and instruction clock (fosc/2)
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pin_q <= 3'h0;
    end else if (ce_i) begin
      pin_q <= {pin_q[1:0], timer_pin_i};
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      instr_q <= 1'b0;
    end else if (ce_i) begin
      instr_q <= !instr_q;
    end
  end
  assign tmr_src = ctrl_q[twp_pkg::CTRL_SRC_BIT];
  // level follows the pin once the last two stages agree
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pin_lvl_q <= 1'b0;
    end else if (ce_i && (pin_q[2] == pin_q[1])) begin
      pin_lvl_q <= pin_q[2];
    end
  end
  // edge bit 1 = falling, 0 = rising
  assign tmr_edge_ok = ctrl_q[twp_pkg::CTRL_EDGE_BIT]
                       ? (pin_lvl_q && !pin_q[2] && !pin_q[1])
                       : (!pin_lvl_q && pin_q[2] && pin_q[1]);

  //==========================================================
  // timer prescaler and timer
  assign tpre.tick = !sleep_q && (tmr_src ? tmr_edge_ok : instr_q);
  assign tpre.clear = wr_timer;
  assign tpre.bypass = !ctrl_q[twp_pkg::CTRL_PRE_EN_BIT];
  assign tpre.rate = ctrl_q[2:0];
  twp_prescaler #(.W(8)) u_tpre (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .p(tpre)
  );
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      timer_q <= 8'h00;
    end else if (ce_i && wr_timer) begin
      timer_q <= wdata_i;
    end else if (ce_i && tpre.out) begin
      timer_q <= timer_q + 8'h01;
    end
  end

  //==========================================================
  // watchdog prescaler and counter on rc tick
  assign wpre.tick = wd_rc_tick_i && wdog_q[twp_pkg::WD_EN_BIT];
  // disabled watchdog keeps its prescaler at zero too
  assign wpre.clear = clr_wd || !wdog_q[twp_pkg::WD_EN_BIT];
  assign wpre.bypass = !wdog_q[twp_pkg::WD_PRE_EN_BIT];
  assign wpre.rate = wdog_q[twp_pkg::WD_RATE_LSB +: 3];
  twp_prescaler #(.W(8)) u_wpre (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .p(wpre)
  );
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wd_cnt_q <= 32'h0;
      wd_rst_q <= 1'b0;
    end else if (ce_i) begin
      wd_rst_q <= 1'b0;
      if (clr_wd || !wdog_q[twp_pkg::WD_EN_BIT]) begin
        wd_cnt_q <= 32'h0;
      end else if (wpre.out) begin
        if (wd_cnt_q >= WD_TIMEOUT - 1) begin
          wd_cnt_q <= 32'h0;
          wd_rst_q <= 1'b1;
        end else begin
          wd_cnt_q <= wd_cnt_q + 32'h1;
        end
      end
    end
  end

  //==========================================================
  // read port
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 8'h00;
    end else if (ce_i) begin
      rdata_q <= 8'h00;
      if (rd_i) begin
        case (addr_i)
          twp_pkg::ADDR_TIMER: rdata_q <= timer_q;
          twp_pkg::ADDR_CTRL: rdata_q <= ctrl_q;
          twp_pkg::ADDR_WDOG: rdata_q <= wdog_q;
          twp_pkg::ADDR_STAT: rdata_q <= {6'h00, wd_rst_q, sleep_q};
          default: rdata_q <= 8'h00;
        endcase
      end
    end
  end
  assign rdata_o = rdata_q;
  assign sleep_o = sleep_q;
  assign wd_reset_o = wd_rst_q;
endmodule
`default_nettype wire

// >>> tb/twp_monitor.sv
`timescale 1ns/10ps
`default_nettype none
//====================
// port checks
module twp_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic sleep_instr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic sleep_o,
  input wire logic wd_reset_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic wt, rt;
  assign wt = wr_i && ce_i && addr_i == twp_pkg::ADDR_TIMER;
  assign rt = rd_i && ce_i && addr_i == twp_pkg::ADDR_TIMER;
  property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_unmap; rd_i && addr_i > twp_pkg::ADDR_STAT |=> rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_crsv; rd_i && addr_i == twp_pkg::ADDR_CTRL
    |=> (rdata_o & ~twp_pkg::CTRL_MASK) == 8'h00; endproperty
  a_crsv: assert property (p_crsv) else $error("ctrl spare bits");
  property p_wrsv; rd_i && addr_i == twp_pkg::ADDR_WDOG
    |=> (rdata_o & ~twp_pkg::WDOG_MASK) == 8'h00; endproperty
  a_wrsv: assert property (p_wrsv) else $error("wdog spare bits");
  property p_rw; wt ##2 rt |=> 8'(rdata_o - $past(wdata_i, 3)) <= 8'h01; endproperty
  a_rw: assert property (p_rw) else $error("timer readback");
  property p_pulse; wd_reset_o |=> !wd_reset_o; endproperty
  a_pulse: assert property (p_pulse) else $error("timeout pulse long");
  property p_hold; sleep_o && !wd_reset_o && !$past(wd_reset_o) |=> sleep_o; endproperty
  a_hold: assert property (p_hold) else $error("sleep dropped");
  property p_enter; sleep_instr_i && ce_i |-> ##[1:2] sleep_o; endproperty
  a_enter: assert property (p_enter) else $error("sleep not entered");
  c_wd: cover property (wd_reset_o);
  c_slp: cover property ($rose(sleep_o));
  c_rw: cover property (wt ##2 rt);
endmodule
bind twp_top twp_monitor mon_u (.sys_clk_i, .rst_n_i, .ce_i, .sleep_instr_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .sleep_o, .wd_reset_o);
`default_nettype wire

// >>> tb/twp_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none
//====================
// pulse source on timer pin
module twp_pulse_src (
  input wire logic sys_clk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  task automatic send(input int n, input int hw);
    repeat (n) begin
      repeat (hw) @(posedge sys_clk_i);
      pin_o <= 1'b1;
      repeat (hw) @(posedge sys_clk_i);
      pin_o <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
//====================
// bench
module tb_top;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sl = 1'b0, wc = 1'b0, rc = 1'b0, wr = 1'b0, rd = 1'b0, pin, slp, wdr;
  logic ce = 1'b1;
  logic [7:0] ad = 8'h00, wd = 8'h00, rdata, v, t, e;
  int error_cnt = 0, check_count = 0, cyc = 0, pulses = 0, n, p;
  twp_top #(.WD_TIMEOUT(4)) dut_u (.sys_clk_i, .rst_n_i, .ce_i(ce), .wd_rc_tick_i(rc),
    .timer_pin_i(pin), .sleep_instr_i(sl), .watchdog_clear_instr_i(wc), .addr_i(ad),
    .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .sleep_o(slp), .wd_reset_o(wdr));
  twp_pulse_src src_u (.sys_clk_i, .pin_o(pin));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    rc <= (cyc % 8 == 0);
    if (wdr === 1'b1) pulses <= pulses + 1;
    if (cyc == 30000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr <= 1'b1; ad <= a; wd <= d;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    rd <= 1'b1; ad <= a;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic instr(input logic s);
    @(posedge sys_clk_i);
    sl <= s; wc <= !s;
    @(posedge sys_clk_i);
    sl <= 1'b0; wc <= 1'b0;
  endtask
  task automatic wait_wd(input int lim);
    n = 0;
    p = pulses;
    while (pulses == p && n < lim) begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask
  task automatic chk(input string s, input logic [15:0] lo, hi, g);
    check_count++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %s exp %0h..%0h got %0h", s, lo, hi, g);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd_reg(twp_pkg::ADDR_WDOG, v);
    chk("wdog", 0, 0, v);
    wr_reg(8'h20, 8'h5A);
    rd_reg(8'h20, v);
    chk("unmap", 0, 0, v);
    wr_reg(twp_pkg::ADDR_WDOG, 8'hFF);
    rd_reg(twp_pkg::ADDR_WDOG, v);
    chk("wdog bits", 8'hBC, 8'hBC, v);
    wr_reg(twp_pkg::ADDR_CTRL, 8'h20);
    for (t = 8'h00; t != 8'hFD; t += 8'h7F) begin
      wr_reg(twp_pkg::ADDR_TIMER, t);
      rd_reg(twp_pkg::ADDR_TIMER, v);
      chk("timer rw", t, t, v);
    end
    wr_reg(twp_pkg::ADDR_TIMER, 8'h00);
    src_u.send(5, 3);
    repeat (6) @(posedge sys_clk_i);
    rd_reg(twp_pkg::ADDR_TIMER, v);
    chk("rise", 5, 5, v);
    wr_reg(twp_pkg::ADDR_CTRL, 8'h30);
    wr_reg(twp_pkg::ADDR_TIMER, 8'hFE);
    src_u.send(3, 4);
    repeat (6) @(posedge sys_clk_i);
    rd_reg(twp_pkg::ADDR_TIMER, v);
    chk("fall wrap", 1, 1, v);
    for (int r = -1; r < 7; r++) begin
      wr_reg(twp_pkg::ADDR_CTRL, r < 0 ? 8'h00 : 8'h08 | 8'(r));
      wr_reg(twp_pkg::ADDR_TIMER, 8'h00);
      repeat (256) @(posedge sys_clk_i);
      rd_reg(twp_pkg::ADDR_TIMER, v);
      e = r < 0 ? 8'd129 : 8'd64 >> r;
      chk("rate", e - 8'h01, e + 8'h01, v);
    end
    wr_reg(twp_pkg::ADDR_CTRL, 8'h00);
    rd_reg(twp_pkg::ADDR_TIMER, t);
    @(posedge sys_clk_i);
    ce <= 1'b0;
    repeat (20) @(posedge sys_clk_i);
    ce <= 1'b1;
    rd_reg(twp_pkg::ADDR_TIMER, v);
    chk("ce hold", 16'(t) + 16'h0001, 16'(t) + 16'h0002, v);
    wr_reg(twp_pkg::ADDR_WDOG, 8'h80);
    instr(1'b0);
    wait_wd(400);
    chk("wd", 20, 52, 16'(n));
    wr_reg(twp_pkg::ADDR_WDOG, 8'hA4);
    instr(1'b0);
    wait_wd(400);
    chk("wd div4", 112, 150, 16'(n));
    wr_reg(twp_pkg::ADDR_WDOG, 8'h80);
    p = pulses;
    repeat (12) begin
      repeat (14) @(posedge sys_clk_i);
      instr(1'b0);
    end
    chk("wd clr", 0, 0, 16'(pulses - p));
    wr_reg(twp_pkg::ADDR_WDOG, 8'h00);
    wait_wd(400);
    chk("wd off", 400, 400, 16'(n));
    wr_reg(twp_pkg::ADDR_CTRL, 8'h00);
    wr_reg(twp_pkg::ADDR_WDOG, 8'hBC);
    instr(1'b1);
    wr_reg(twp_pkg::ADDR_WDOG, 8'h00);
    rd_reg(twp_pkg::ADDR_STAT, v);
    chk("asleep", 1, 1, v & 8'h01);
    rd_reg(twp_pkg::ADDR_TIMER, t);
    repeat (20) @(posedge sys_clk_i);
    rd_reg(twp_pkg::ADDR_TIMER, v);
    chk("frozen", t, t, v);
    wait_wd(9000);
    chk("wd sleep", 7900, 8300, 16'(n));
    print_verdict();
  end
endmodule
`default_nettype wire
